// ### rtl/flash_pins_regs.vh
// constants for the flash bus pin interface: clock rate, timings, codes
// assumes a single 200 MHz system clock and times given in nanoseconds
`ifndef FLASH_PINS_REGS_VH
`define FLASH_PINS_REGS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_MHZ            32'd200
`define NS_PER_US          32'd1000
`define T_RST_ACCESS_NS    32'd150
`define T_RST_READY_NS     32'd200
`define T_STS_PULSE_NS     32'd250
`define CNT_W              16

// ----------------------------------------
// read source select codes
// ----------------------------------------
`define SRC_ARRAY          3'h0
`define SRC_SIGNATURE      3'h1
`define SRC_PROTECT        3'h2
`define SRC_QUERY          3'h3
`define SRC_STATUS         3'h4

// ----------------------------------------
// fields and modes
// ----------------------------------------
`define BUSY_STATUS_BIT    7
`define STS_MODE_RB        1'b0
`define STS_MODE_PULSE     1'b1
`define RDMODE_ASYNC       1'b1
`define RDMODE_SYNC        1'b0
`define SYNC_LEN           2

`endif

// ### rtl/flash_bus_pin_interface.v
// pin-level bus interface of a 16-bit parallel flash: latching, tri-state,
// reset/power-down, burst ready and open-drain status output.
// assumes all host pins are asynchronous to clk_i; the flash core sits on
// the user-side ports and runs on clk_i.
`timescale 1ns/1ps
`include "flash_pins_regs.vh"

module flash_bus_pin_interface #(
	parameter AW            = 21,
	parameter DW            = 16,
	parameter RST_ACCESS_NS = `T_RST_ACCESS_NS,
	parameter RST_READY_NS  = `T_RST_READY_NS,
	parameter STS_PULSE_NS  = `T_STS_PULSE_NS
) (
	// clock and reset
	input  wire          clk_i,
	input  wire          rstn_i,
	// host pins
	input  wire          chip_sel_n_i,
	input  wire          out_gate_n_i,
	input  wire          wr_strobe_n_i,
	input  wire          addr_latch_n_i,
	input  wire          bus_clk_i,
	input  wire          reset_powerdown_n_i,
	input  wire          program_erase_permit_i,
	input  wire [AW-1:0] word_address_lines_i,
	input  wire [DW-1:0] data_lines_i,
	output reg  [DW-1:0] data_lines_o,
	output reg           data_lines_oe_n_o,
	output wire          data_valid_ready_o,
	output wire          data_valid_ready_oe_n_o,
	output wire          controller_status_out_o,
	output reg           controller_status_out_oe_n_o,
	// configuration
	input  wire          cfg_wr_i,
	input  wire          cfg_read_mode_i,
	input  wire          clk_falling_i,
	input  wire          ready_early_i,
	input  wire          burst_cont_i,
	input  wire          sts_pulse_cfg_i,
	// core side
	input  wire [DW-1:0] array_data_i,
	input  wire [DW-1:0] signature_i,
	input  wire [DW-1:0] protect_i,
	input  wire [DW-1:0] query_i,
	input  wire [DW-1:0] status_reg_i,
	input  wire [2:0]    read_src_i,
	input  wire          pec_busy_i,
	input  wire          pec_start_i,
	input  wire          pec_done_i,
	input  wire          data_invalid_i,
	input  wire          data_invalid_next_i,
	input  wire          cmd_ready_i,
	output wire          cmd_valid_o,
	output wire [AW-1:0] cmd_addr_o,
	output wire [DW-1:0] cmd_data_o,
	output wire          cmd_accept_o,
	output reg  [AW-1:0] read_addr_o,
	output reg  [AW-1:0] op_addr_o,
	output wire          hw_reset_o,
	output reg           abort_o,
	output wire          selected_o,
	output wire          access_ready_o,
	output wire          permit_o,
	output wire          sync_mode_o
);

	// ----------------------------------------
	// derived counts
	// ----------------------------------------
	// least times round up, longest time rounds down
	localparam [31:0] ACC_FULL = (RST_ACCESS_NS * `CLK_MHZ + `NS_PER_US - 1) / `NS_PER_US;
	localparam [31:0] RDY_FULL = (RST_READY_NS * `CLK_MHZ) / `NS_PER_US;
	localparam [31:0] PLS_FULL = (STS_PULSE_NS * `CLK_MHZ + `NS_PER_US - 1) / `NS_PER_US;
	// counters are CNT_W wide; the cut to that width is deliberate
	localparam [`CNT_W-1:0] ACC_CYC = ACC_FULL[`CNT_W-1:0];
	localparam [`CNT_W-1:0] RDY_CYC = RDY_FULL[`CNT_W-1:0];
	localparam [`CNT_W-1:0] PLS_CYC = PLS_FULL[`CNT_W-1:0];
	localparam NPIN = 7 + AW + DW;

	function rise;
		input prev;
		input cur;
		rise = ~prev & cur;
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	reg [NPIN-1:0] s1_r;
	reg [NPIN-1:0] s2_r;
	reg [6:0]      p_r;
	wire [NPIN-1:0] pins = {chip_sel_n_i, out_gate_n_i, wr_strobe_n_i, addr_latch_n_i,
		bus_clk_i, reset_powerdown_n_i, program_erase_permit_i,
		word_address_lines_i, data_lines_i};

	// two flops per pin; only stage two is read by logic
	genvar g;
	generate
		for (g = 0; g < NPIN; g = g + 1) begin : g_sync
			always @(posedge clk_i) begin
				s1_r[g] <= pins[g];
				s2_r[g] <= s1_r[g];
			end
		end
	endgenerate

	wire          ce_n  = s2_r[NPIN-1];
	wire          oe_n  = s2_r[NPIN-2];
	wire          we_n  = s2_r[NPIN-3];
	wire          lat_n = s2_r[NPIN-4];
	wire          kclk  = s2_r[NPIN-5];
	wire          rp_n  = s2_r[NPIN-6];
	wire [AW-1:0] addr  = s2_r[DW +: AW];
	wire [DW-1:0] din   = s2_r[DW-1:0];

	// previous values for edge detection
	always @(posedge clk_i) begin
		p_r <= s2_r[NPIN-1:NPIN-7];
	end

	wire ce_rise  = rise(p_r[6], ce_n);
	wire lat_rise = rise(p_r[3], lat_n);
	wire lat_fall = rise(lat_n, p_r[3]);
	wire rp_fall  = rise(rp_n, p_r[1]);
	wire k_edge   = clk_falling_i ? rise(kclk, p_r[2]) : rise(p_r[2], kclk);

	assign permit_o = s2_r[NPIN-7];

	// ----------------------------------------
	// reset, power-down and access delay
	// ----------------------------------------
	reg [`CNT_W-1:0] acc_cnt_r;
	reg              rd_mode_r;
	wire             pd = ~rp_n | ~rstn_i;

	// status clear and power-down level to the core
	assign hw_reset_o = pd;
	assign selected_o = ~ce_n & ~pd;
	assign access_ready_o = (acc_cnt_r == {`CNT_W{1'b0}});

	// count out the reset-to-access delay after release
	always @(posedge clk_i) begin
		if (pd) begin
			acc_cnt_r <= ACC_CYC;
		end else if (!access_ready_o) begin
			acc_cnt_r <= acc_cnt_r - 1'b1;
		end
	end

	// asynchronous read after reset; mode bit from configuration
	always @(posedge clk_i) begin
		if (pd) begin
			rd_mode_r <= `RDMODE_ASYNC;
		end else if (cfg_wr_i) begin
			rd_mode_r <= cfg_read_mode_i;
		end
	end

	wire sync_md = (rd_mode_r == `RDMODE_SYNC);
	wire active  = selected_o & access_ready_o;
	assign sync_mode_o = sync_md;

	// abort pulse when reset falls on a running operation
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			abort_o <= 1'b0;
		end else begin
			abort_o <= rp_fall & pec_busy_i;
		end
	end

	// ----------------------------------------
	// address latch
	// ----------------------------------------
	reg [AW-1:0] a_lat_r;
	reg [AW-1:0] a_lat_nxt;
	reg          latched_r;
	wire         sync_load = sync_md & active & ~latched_r & ((k_edge & ~lat_n) | lat_rise);
	wire         burst_adv = sync_md & active & latched_r & k_edge & ~oe_n;

	// transparent when latch low; first edge or latch rise
	always @* begin
		a_lat_nxt = a_lat_r;
		if (!sync_md) begin
			if (!lat_n) begin
				a_lat_nxt = addr;
			end
		end else if (sync_load) begin
			a_lat_nxt = addr;
		end else if (burst_adv) begin
			a_lat_nxt = a_lat_r + 1'b1;
		end
	end

	// latched flag rearms on a new latch cycle or deselect
	always @(posedge clk_i) begin
		if (pd) begin
			a_lat_r   <= {AW{1'b0}};
			latched_r <= 1'b0;
		end else begin
			a_lat_r <= a_lat_nxt;
			// a load in the cycle the latch reopens still counts as taken
			if (sync_load) begin
				latched_r <= 1'b1;
			end else if (ce_n | lat_fall) begin
				latched_r <= 1'b0;
			end
			read_addr_o <= a_lat_nxt;
		end
	end

	// hold the program/erase target address once started
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			op_addr_o <= {AW{1'b0}};
		end else if (pec_start_i) begin
			op_addr_o <= a_lat_r;
		end
	end

	// ----------------------------------------
	// write capture into two-entry buffer
	// ----------------------------------------
	reg [AW+DW-1:0] buf_r [0:1];
	reg             wp_r;
	reg             rdp_r;
	reg [1:0]       cnt_r;
	reg             wr_act_r;
	// output gate is expected high in a write; with strobe and gate both low neither a write nor a read is done
	wire            wr_act = active & ~we_n & oe_n;
	// end of write is the first of strobe or select rising
	wire            wr_end = wr_act_r & (~wr_act | ce_rise);
	wire            push   = wr_end & cmd_accept_o;
	wire            pop    = cmd_valid_o & cmd_ready_i;

	assign cmd_accept_o = (cnt_r != 2'd2);
	assign cmd_valid_o  = (cnt_r != 2'd0);
	assign cmd_addr_o   = buf_r[rdp_r][AW+DW-1:DW];
	assign cmd_data_o   = buf_r[rdp_r][DW-1:0];

	// a full buffer drops the word; cmd_accept_o lets the core see it
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			wr_act_r <= 1'b0;
			wp_r     <= 1'b0;
			rdp_r    <= 1'b0;
			cnt_r    <= 2'd0;
		end else begin
			wr_act_r <= wr_act;
			if (push) begin
				buf_r[wp_r] <= {a_lat_nxt, din};
				wp_r        <= ~wp_r;
			end
			if (pop) begin
				rdp_r <= ~rdp_r;
			end
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	// ----------------------------------------
	// read data path
	// ----------------------------------------
	reg [DW-1:0] dsel;

	always @* begin
		case (read_src_i)
			`SRC_ARRAY:     dsel = array_data_i;
			`SRC_SIGNATURE: dsel = signature_i;
			`SRC_PROTECT:   dsel = protect_i;
			`SRC_QUERY:     dsel = query_i;
			`SRC_STATUS:    dsel = status_reg_i;
			default:        dsel = array_data_i;
		endcase
		// ready bit low while the controller runs
		if (pec_busy_i) begin
			dsel[`BUSY_STATUS_BIT] = 1'b0;
		end
	end

	// float unless selected and access-ready with output gate low, strobe high and not in reset
	always @(posedge clk_i) begin
		if (pd) begin
			data_lines_o      <= {DW{1'b0}};
			data_lines_oe_n_o <= 1'b1;
		end else begin
			data_lines_o      <= dsel;
			data_lines_oe_n_o <= ~(active & ~oe_n & we_n);
		end
	end

	// ----------------------------------------
	// burst data-valid ready (open drain)
	// ----------------------------------------
	reg  rdy_low_r;
	wire burst_rd = sync_md & burst_cont_i & active & we_n;

	// early option uses the next-cycle invalid flag
	always @(posedge clk_i) begin
		if (pd | ~burst_rd) begin
			rdy_low_r <= 1'b0;
		end else if (k_edge) begin
			rdy_low_r <= ready_early_i ? data_invalid_next_i : data_invalid_i;
		end
	end

	assign data_valid_ready_o      = 1'b0;
	assign data_valid_ready_oe_n_o = ~(burst_rd & rdy_low_r);

	// ----------------------------------------
	// controller status output (open drain)
	// ----------------------------------------
	reg              sts_mode_r;
	reg [`CNT_W-1:0] hold_cnt_r;
	reg [`CNT_W-1:0] pls_cnt_r;
	reg              drive_low;

	// ready/busy after reset, pulse mode only by command
	always @(posedge clk_i) begin
		if (pd) begin
			sts_mode_r <= `STS_MODE_RB;
		end else if (sts_pulse_cfg_i) begin
			sts_mode_r <= `STS_MODE_PULSE;
		end
	end

	// hold low in reset only if busy at entry, bounded
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			hold_cnt_r <= {`CNT_W{1'b0}};
		end else if (rp_fall & pec_busy_i) begin
			hold_cnt_r <= RDY_CYC;
		end else if (hold_cnt_r != {`CNT_W{1'b0}}) begin
			hold_cnt_r <= hold_cnt_r - 1'b1;
		end
	end

	always @(posedge clk_i) begin
		if (pd) begin
			pls_cnt_r <= {`CNT_W{1'b0}};
		end else if (pec_done_i & (sts_mode_r == `STS_MODE_PULSE)) begin
			pls_cnt_r <= PLS_CYC;
		end else if (pls_cnt_r != {`CNT_W{1'b0}}) begin
			pls_cnt_r <= pls_cnt_r - 1'b1;
		end
	end

	// low while busy in ready/busy mode
	always @* begin
		if (pd) begin
			// the cycle that loads the hold counter must not release the pin
			drive_low = (hold_cnt_r != {`CNT_W{1'b0}}) | (rp_fall & pec_busy_i);
		end else if (sts_mode_r == `STS_MODE_RB) begin
			drive_low = pec_busy_i;
		end else begin
			drive_low = (pls_cnt_r != {`CNT_W{1'b0}});
		end
	end

	always @(posedge clk_i) begin
		if (!rstn_i) begin
			controller_status_out_oe_n_o <= 1'b1;
		end else begin
			controller_status_out_oe_n_o <= ~drive_low;
		end
	end

	assign controller_status_out_o = 1'b0;

endmodule // flash_bus_pin_interface

// ### tb/flash_pins_props.sv
// checker: timing relations at the flash pin interface ports
// assumes binding into flash_bus_pin_interface with default timings
`timescale 1ns/1ps
module flash_pins_chk (
	// clock
	input logic clk_i,
	input logic rstn_i,
	// inputs
	input logic chip_sel_n_i,
	input logic out_gate_n_i,
	input logic pec_busy_i,
	input logic sts_pulse_cfg_i,
	// outputs
	input logic data_lines_oe_n_o,
	input logic data_valid_ready_oe_n_o,
	input logic controller_status_out_oe_n_o,
	input logic hw_reset_o,
	input logic abort_o,
	input logic access_ready_o,
	input logic sync_mode_o
);
	logic pm_r = 1'b0;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	// pulse mode copy; any reset goes back to ready/busy
	always @(posedge clk_i) begin
		if (!rstn_i || hw_reset_o)
			pm_r <= 1'b0;
		else if (sts_pulse_cfg_i)
			pm_r <= 1'b1;
	end

	// a read held past the sync stages, and a release of reset
	sequence read_s;
		(!chip_sel_n_i && !out_gate_n_i && access_ready_o && !hw_reset_o && !sync_mode_o)[*5];
	endsequence
	sequence release_s;
		$fell(hw_reset_o) ##1 !access_ready_o[*8];
	endsequence

	reset_float_a: assert property (
		hw_reset_o[*2] |-> data_lines_oe_n_o && !sync_mode_o) else $error("not quiet in reset");
	gate_float_a: assert property (
		out_gate_n_i[*4] |-> data_lines_oe_n_o) else $error("driven with gate high");
	read_drive_a: assert property (
		read_s |-> !data_lines_oe_n_o) else $error("read not driven");
	ready_hiz_a: assert property (
		(!sync_mode_o)[*2] |-> data_valid_ready_oe_n_o) else $error("ready pulled in async");
	sts_busy_a: assert property (
		!pm_r && pec_busy_i && !hw_reset_o |=> !controller_status_out_oe_n_o)
		else $error("status not low when busy");
	abort_release_a: assert property (
		abort_o |-> ##[1:45] controller_status_out_oe_n_o) else $error("status held too long");
	rst_quiet_a: assert property (
		(!pec_busy_i)[*2] ##0 $rose(hw_reset_o) ##1 hw_reset_o[*4]
		|-> controller_status_out_oe_n_o) else $error("status low in idle reset");
	access_wait_a: assert property (
		release_s |-> ##[10:30] access_ready_o) else $error("access delay wrong");
endmodule // flash_pins_chk

bind flash_bus_pin_interface flash_pins_chk chk (.*);

// ### tb/flash_host_model.sv
// host model: drives the flash pins as a processor bus would
// assumes one system clock; the bench resolves the data wire
`timescale 1ns/1ps
module flash_host_model (
	// clock
	input  logic        clk_i,
	// pins
	output logic        chip_sel_n_o,
	output logic        out_gate_n_o,
	output logic        wr_strobe_n_o,
	output logic        addr_latch_n_o,
	output logic [20:0] word_address_lines_o,
	output logic [15:0] data_lines_o
);
	// idle bus: deselected, latch transparent
	initial begin
		{chip_sel_n_o, out_gate_n_o, wr_strobe_n_o, addr_latch_n_o} = 4'hE;
		word_address_lines_o = 21'h0;
		data_lines_o = 16'h0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// write with gate high; lat closes the latch, then lines move
	task automatic wr(input logic [20:0] a, input logic [15:0] d, input logic lat);
		chip_sel_n_o <= 1'b0;
		word_address_lines_o <= a;
		data_lines_o <= d;
		cyc(4);
		addr_latch_n_o <= lat;
		cyc(4);
		word_address_lines_o <= lat ? ~a : a;
		wr_strobe_n_o <= 1'b0;
		cyc(6);
		wr_strobe_n_o <= 1'b1;
		cyc(4);
		{chip_sel_n_o, addr_latch_n_o} <= 2'h2;
		data_lines_o <= ~d; // released lines must not keep the word
		cyc(6);
	endtask

	// select, gate level g (low only outside writes)
	task automatic rd(input logic [20:0] a, input logic g);
		{chip_sel_n_o, out_gate_n_o} <= {1'b0, g};
		word_address_lines_o <= a;
		cyc(6);
	endtask

	task automatic idle;
		{chip_sel_n_o, out_gate_n_o} <= 2'h3;
		cyc(4);
	endtask
endmodule // flash_host_model

// ### tb/flash_bus_pin_interface_tb_top.sv
// bench: host model on the pins, core side driven here, writes scored
// assumes the host model and checker are compiled first
`timescale 1ns/1ps
module flash_bus_pin_interface_tb_top;
	logic        clk_i = 1'b0, rstn_i = 1'b0, reset_powerdown_n_i = 1'b0;
	logic        program_erase_permit_i = 1'b1, bus_clk_i = 1'b0, bclk_en = 1'b0, rdy_exp;
	logic        cfg_wr_i = 1'b0, cfg_read_mode_i = 1'b1, sts_pulse_cfg_i = 1'b0;
	logic        clk_falling_i = 1'b0, ready_early_i = 1'b0, burst_cont_i = 1'b0;
	logic        data_invalid_i = 1'b0, data_invalid_next_i = 1'b0, cmd_ready_i = 1'b1;
	logic        pec_busy_i = 1'b0, pec_start_i = 1'b0, pec_done_i = 1'b0;
	logic [2:0]  read_src_i = 3'h0;
	logic [15:0] src [0:4] = '{default: 16'h0000};
	logic [15:0] array_data_i, signature_i, protect_i, query_i, status_reg_i;
	logic [15:0] hd, d, data_lines_i, data_lines_o, cmd_data_o;
	logic [20:0] a, word_address_lines_i, cmd_addr_o, read_addr_o, op_addr_o;
	logic        chip_sel_n_i, out_gate_n_i, wr_strobe_n_i, addr_latch_n_i;
	logic        data_lines_oe_n_o, data_valid_ready_o, data_valid_ready_oe_n_o;
	logic        controller_status_out_o, controller_status_out_oe_n_o, cmd_valid_o;
	logic        cmd_accept_o, hw_reset_o, abort_o, selected_o, access_ready_o;
	logic        permit_o, sync_mode_o;
	logic [36:0] exp_q [$];
	int          n_errors = 0, comparisons = 0, n_abort = 0, cyc_n = 0;

	assign {array_data_i, signature_i, protect_i} = {src[0], src[1], src[2]};
	assign {query_i, status_reg_i} = {src[3], src[4]};
	// shared data wire: the device wins while it drives
	assign data_lines_i = data_lines_oe_n_o ? hd : data_lines_o;

	// system clock, and a bus clock that runs only inside a clocked frame
	initial forever #2.5 clk_i = ~clk_i;
	always #80 if (bclk_en) bus_clk_i = ~bus_clk_i;

	flash_host_model host (
		.clk_i                (clk_i),
		.chip_sel_n_o         (chip_sel_n_i),
		.out_gate_n_o         (out_gate_n_i),
		.wr_strobe_n_o        (wr_strobe_n_i),
		.addr_latch_n_o       (addr_latch_n_i),
		.word_address_lines_o (word_address_lines_i),
		.data_lines_o         (hd)
	);
	flash_bus_pin_interface dut (.*);

	task automatic chk(input string nm, input logic [36:0] s, input logic [36:0] e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wait_acc;
		repeat (80) if (access_ready_o !== 1'b1) @(posedge clk_i);
		chk("access", access_ready_o, 1);
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// popped words against the oldest note; abort pulses; hang limit
	always @(posedge clk_i) begin
		if (cmd_valid_o === 1'b1 && cmd_ready_i === 1'b1)
			chk("cmd", {cmd_addr_o, cmd_data_o}, exp_q.size() ? exp_q.pop_front() : 'x);
		if (abort_o === 1'b1)
			n_abort++;
		cyc_n++;
		if (cyc_n == 30000) begin
			n_errors++;
			report_and_stop;
		end
	end

	initial begin
		a = 21'($urandom(32'h77C8));
		{clk_falling_i, ready_early_i, burst_cont_i} <= 3'($urandom);
		{data_invalid_i, data_invalid_next_i} <= 2'($urandom);
		// pin and system reset start together
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		host.cyc(10);
		reset_powerdown_n_i <= 1'b1;
		wait_acc;
		chk("idle", {controller_status_out_oe_n_o, data_valid_ready_oe_n_o}, 2'h3);
		chk("od level", {controller_status_out_o, data_valid_ready_o}, 2'h0);
		chk("mode", sync_mode_o, 0);
		$display("reset test done");
		// two words fill the buffer, a third is dropped, then it drains
		cmd_ready_i <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (i == 3) begin
				chk("full", cmd_accept_o, 0);
				cmd_ready_i <= 1'b1;
				host.cyc(8);
			end
			a = 21'($urandom);
			d = 16'($urandom);
			if (i != 2)
				exp_q.push_back({a, d});
			host.wr(a, d, i[0]);
		end
		host.cyc(8);
		chk("left", exp_q.size(), 0);
		$display("write test done");
		// every read source and an out-of-range code, then gate high
		for (int s = 0; s < 6; s++) begin
			src[s % 5] <= 16'($urandom);
			read_src_i <= 3'(s);
			// permit may drop while no operation runs
			program_erase_permit_i <= s[0];
			host.rd(a, 1'b0);
			chk("dq", {data_lines_oe_n_o, data_lines_o}, {1'b0, src[s % 5]});
			chk("sel", selected_o, 1);
			chk("permit", permit_o, s[0]);
			chk("raddr", read_addr_o, a);
			host.rd(a, 1'b1);
			chk("gate", data_lines_oe_n_o, 1);
			host.idle;
			chk("standby", selected_o, 0);
		end
		$display("read test done");
		// busy controller, then its target address must stay put
		// permit held high through the operation
		program_erase_permit_i <= 1'b1;
		pec_busy_i <= 1'b1;
		src[4] <= 16'hFFFF;
		read_src_i <= 3'h4;
		host.rd(a, 1'b0);
		chk("busy bit", data_lines_o[7], 0);
		chk("sts busy", controller_status_out_oe_n_o, 0);
		pec_start_i <= 1'b1;
		host.cyc(1);
		pec_start_i <= 1'b0;
		host.rd(~a, 1'b0);
		chk("op addr", op_addr_o, a);
		// reset pin mid-operation with a read still asked for
		reset_powerdown_n_i <= 1'b0;
		host.cyc(6);
		pec_busy_i <= 1'b0;
		host.cyc(60);
		chk("abort", n_abort, 1);
		chk("float", {data_lines_oe_n_o, controller_status_out_oe_n_o}, 2'h3);
		reset_powerdown_n_i <= 1'b1;
		host.idle;
		wait_acc;
		$display("abort test done");
		// pulse mode completion
		sts_pulse_cfg_i <= 1'b1;
		host.cyc(1);
		{sts_pulse_cfg_i, pec_done_i} <= 2'h1;
		host.cyc(1);
		pec_done_i <= 1'b0;
		host.cyc(3);
		chk("pulse", controller_status_out_oe_n_o, 0);
		host.cyc(60);
		chk("pulse end", controller_status_out_oe_n_o, 1);
		// clocked mode: address taken on an active bus clock edge
		{cfg_read_mode_i, cfg_wr_i} <= 2'h1;
		host.cyc(1);
		cfg_wr_i <= 1'b0;
		// both active bus clock edges, random ready settings each time
		for (int m = 0; m < 2; m++) begin
			clk_falling_i <= m[0];
			{ready_early_i, burst_cont_i} <= 2'($urandom);
			{data_invalid_i, data_invalid_next_i} <= 2'($urandom);
			a = 21'($urandom);
			host.rd(a, 1'b1);
			chk("sync", sync_mode_o, 1);
			bclk_en <= 1'b1;
			host.cyc(70);
			bclk_en <= 1'b0;
			chk("burst addr", read_addr_o, a);
			rdy_exp = !(burst_cont_i && (ready_early_i ? data_invalid_next_i : data_invalid_i));
			chk("ready", data_valid_ready_oe_n_o, rdy_exp);
			host.idle;
		end
		$display("mode test done");
		// quiet reset: async reads and ready/busy come back
		reset_powerdown_n_i <= 1'b0;
		host.cyc(10);
		chk("quiet", {controller_status_out_oe_n_o, sync_mode_o}, 2'h2);
		reset_powerdown_n_i <= 1'b1;
		wait_acc;
		pec_busy_i <= 1'b1;
		host.cyc(3);
		chk("rb mode", controller_status_out_oe_n_o, 0);
		$display("quiet reset test done");
		report_and_stop;
	end
endmodule // flash_bus_pin_interface_tb_top
